// ### hw/mpwm_pkg.sv
/*
 * Constants, command codes and register map of the frame-loaded
 * multichannel pulse-width generator.
 * Assumes a 25 MHz system clock; all pin timing derives from it.
 */
package mpwm_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int NUM_CH = 48;
    localparam int CH_W = 12;
    localparam int CMD_W = 8;
    localparam int COR_W = 6;
    localparam int FRAME_BITS = NUM_CH * CH_W + CMD_W;
    localparam int CNT_W = 12;
    localparam int BITCNT_W = 10;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 10'h247;
    localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;

    // ----------------------------------------------------------------
    // Correction arithmetic: v * 2/3 * (c + 32) / 64 = v * (c + 32) / 96
    // ----------------------------------------------------------------
    localparam int PROD_W = 19;
    localparam logic [PROD_W-1:0] COR_BIAS = 19'h00020;
    localparam logic [PROD_W-1:0] COR_DIV = 19'h00060;

    // ----------------------------------------------------------------
    // Status frame positions inside the shift register
    // ----------------------------------------------------------------
    localparam int ST_CMD_LSB = 580;
    localparam int ST_SYNC = 578;
    localparam int ST_CRD = 576;
    localparam int ST_COR_TOP = 575;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int BLANK_TIME_NS = 50000;
    localparam int LATCH_MAX_NS = 5000;
    localparam int BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK_W = 11;

    // ----------------------------------------------------------------
    // Commands (upper nibble of the command field)
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MPWM_CMD_SYNC_UPD = 4'h0,
        MPWM_CMD_ASYNC_UPD = 4'h1,
        MPWM_CMD_COR_LOAD = 4'h2,
        MPWM_CMD_OUT_EN = 4'h3,
        MPWM_CMD_OUT_DIS = 4'h4,
        MPWM_CMD_SELF_TEST = 4'h5,
        MPWM_CMD_PHASE = 4'h6,
        MPWM_CMD_COR_TOGGLE = 4'h7
    } mpwm_cmd_t;

    // ----------------------------------------------------------------
    // APB register map
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_COUNT = 12'h008;
    localparam logic CTRL_ALLOW_RST = 1'b1;
    localparam int STAT_SYNC = 0;
    localparam int STAT_CRD = 1;
    localparam int STAT_OE = 2;
    localparam int STAT_PEND = 3;
    localparam int STAT_CMD_LSB = 4;

endpackage

// ### hw/mpwm_top.sv
/*
 * Frame-loaded 48-channel pulse-width generator with APB status port.
 * Assumes shift clock, serial data, latch/blank and modulation clock
 * arrive asynchronously and are far slower than the 25 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mpwm_top
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic shift_clock_in_i,
    input wire logic serial_in_i,
    input wire logic latch_blank_pin_i,
    input wire logic modulation_clock_i,
    output logic shift_clock_out_o,
    output logic serial_out_o,
    output logic [mpwm_pkg::NUM_CH-1:0] pwm_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import mpwm_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic sck_m_q, sck_s_q, sck_p_q;
    logic sdi_m_q, sdi_s_q;
    logic lb_m_q, lb_s_q, lb_p_q;
    logic mck_m_q, mck_s_q, mck_p_q;

    // Two flops per pin, then one more on the shift clock, latch and modulation clock pins for edge detection
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_p_q <= 1'b0;
            sdi_m_q <= 1'b0;
            sdi_s_q <= 1'b0;
            lb_m_q <= 1'b0;
            lb_s_q <= 1'b0;
            lb_p_q <= 1'b0;
            mck_m_q <= 1'b0;
            mck_s_q <= 1'b0;
            mck_p_q <= 1'b0;
        end
        else if (ce_i)
        begin
            sck_m_q <= shift_clock_in_i;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
            sdi_m_q <= serial_in_i;
            sdi_s_q <= sdi_m_q;
            lb_m_q <= latch_blank_pin_i;
            lb_s_q <= lb_m_q;
            lb_p_q <= lb_s_q;
            mck_m_q <= modulation_clock_i;
            mck_s_q <= mck_m_q;
            mck_p_q <= mck_s_q;
        end
    end

    logic sck_rise, lb_rise, mck_rise;
    assign sck_rise = sck_s_q & ~sck_p_q;
    assign lb_rise = lb_s_q & ~lb_p_q;
    assign mck_rise = mck_s_q & ~mck_p_q;

    // Buffered copy of the shift clock, one register stage
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            shift_clock_out_o <= 1'b0;
        else if (ce_i)
            shift_clock_out_o <= sck_s_q;
    end

    // ----------------------------------------------------------------
    // Blank detection and block-wide reset
    // ----------------------------------------------------------------
    logic [BLANK_W-1:0] blank_cnt_q;
    logic blank_q;
    logic srst;
    assign srst = rst_i | blank_q;

    // Counts how long the latch pin stays high
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            blank_cnt_q <= '0;
            blank_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!lb_s_q)
            begin
                blank_cnt_q <= '0;
                blank_q <= 1'b0;
            end
            else if (blank_cnt_q == BLANK_W'(BLANK_CYC - 1))
                blank_q <= 1'b1;
            else
                blank_cnt_q <= blank_cnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Control and status state
    // ----------------------------------------------------------------
    logic [FRAME_BITS-1:0] sr_q;
    logic [BITCNT_W-1:0] bit_cnt_q;
    logic [CMD_W-1:0] last_cmd_q;
    logic crd_q, oe_q, pend_q, sync_err_q, allow_q;
    logic [CNT_W-1:0] mcnt_q;
    logic period_start;
    mpwm_cmd_t cmd;
    logic do_sync, do_async, do_cor, do_oe;

    assign cmd = mpwm_cmd_t'(sr_q[CMD_W-1:CMD_W-4]);
    assign do_sync = lb_rise & (cmd == MPWM_CMD_SYNC_UPD);
    assign do_async = lb_rise & (cmd == MPWM_CMD_ASYNC_UPD);
    assign do_cor = lb_rise & (cmd == MPWM_CMD_COR_LOAD);
    assign do_oe = lb_rise & (cmd == MPWM_CMD_OUT_EN) & ~oe_q;
    assign period_start = mck_rise & (mcnt_q == CNT_MAX);

    // Frame bit counter, restarts after every latch
    always_ff @(posedge mclk_i)
    begin
        if (srst)
            bit_cnt_q <= '0;
        else if (ce_i)
        begin
            if (lb_s_q)
                bit_cnt_q <= '0;
            else if (sck_rise)
                bit_cnt_q <= (bit_cnt_q == LAST_BIT) ? '0 : bit_cnt_q + 1'b1;
        end
    end

    // Sync error: set wins over software clear
    logic sync_clr;
    always_ff @(posedge mclk_i)
    begin
        if (srst)
            sync_err_q <= 1'b0;
        else if (ce_i)
        begin
            if (lb_rise && (bit_cnt_q != '0 || sck_s_q))
                sync_err_q <= 1'b1;
            else if (sync_clr)
                sync_err_q <= 1'b0;
        end
    end

    // Command capture and command-driven flags
    always_ff @(posedge mclk_i)
    begin
        if (srst)
        begin
            last_cmd_q <= '0;
            crd_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else if (ce_i && lb_rise)
        begin
            last_cmd_q <= sr_q[CMD_W-1:0];
            case (cmd)
                MPWM_CMD_OUT_EN: oe_q <= 1'b1;
                MPWM_CMD_OUT_DIS: oe_q <= 1'b0;
                MPWM_CMD_COR_TOGGLE: crd_q <= ~crd_q;
                default: ;
            endcase
        end
    end

    // Pending synchronous transfer waits for the next period start
    always_ff @(posedge mclk_i)
    begin
        if (srst)
            pend_q <= 1'b0;
        else if (ce_i)
        begin
            if (do_sync)
                pend_q <= 1'b1;
            else if (do_async || period_start)
                pend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Frame shift register with status parallel load
    // ----------------------------------------------------------------
    logic [COR_W-1:0] cor_q [NUM_CH];
    logic [FRAME_BITS-1:0] status_frame;

    // Status frame: command nibble, flags, corrections top channel first
    always_comb
    begin
        status_frame = '0;
        status_frame[ST_CMD_LSB +: 4] = last_cmd_q[CMD_W-1:CMD_W-4];
        status_frame[ST_SYNC] = sync_err_q;
        status_frame[ST_CRD] = crd_q;
        for (int k = 0; k < NUM_CH; k++)
            status_frame[ST_COR_TOP - COR_W*(NUM_CH-1-k) -: COR_W] = cor_q[k];
    end

    // Shifts on shift clock edges, loads status while latch is high
    always_ff @(posedge mclk_i)
    begin
        if (srst)
            sr_q <= '0;
        else if (ce_i)
        begin
            if (lb_s_q && !lb_rise)
                sr_q <= status_frame;
            else if (sck_rise && !lb_s_q)
                sr_q <= {sr_q[FRAME_BITS-2:0], sdi_s_q};
        end
    end

    assign serial_out_o = sr_q[FRAME_BITS-1];

    // ----------------------------------------------------------------
    // Correction multiplier
    // ----------------------------------------------------------------
    function automatic logic [CH_W-1:0] corr_calc(
        input logic [CH_W-1:0] v,
        input logic [COR_W-1:0] c,
        input logic bypass
    );
        logic [PROD_W-1:0] p;
        p = PROD_W'(v) * (PROD_W'(c) + COR_BIAS);
        if (bypass)
            corr_calc = v;
        else
            corr_calc = CH_W'(p / COR_DIV);
    endfunction

    // ----------------------------------------------------------------
    // Modulation counter
    // ----------------------------------------------------------------
    // Free running; restarts when outputs become enabled
    always_ff @(posedge mclk_i)
    begin
        if (srst)
            mcnt_q <= '0;
        else if (ce_i)
        begin
            if (do_oe)
                mcnt_q <= '0;
            else if (mck_rise)
                mcnt_q <= mcnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Per-channel registers and outputs
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [CH_W-1:0] channel_field_field;
            logic [CH_W-1:0] result;
            logic [CH_W-1:0] stage_q;
            logic [CH_W-1:0] active_q;

            // Channel g field; taken from the serial-in fed shift path
            assign channel_field_field = sr_q[CMD_W + CH_W*g +: CH_W];
            assign result = corr_calc(channel_field_field, cor_q[g], crd_q);

            // Correction setting load
            always_ff @(posedge mclk_i)
            begin
                if (srst)
                    cor_q[g] <= '0;
                else if (ce_i && do_cor)
                    cor_q[g] <= channel_field_field[COR_W-1:0];
            end

            // Staging width register
            always_ff @(posedge mclk_i)
            begin
                if (srst)
                    stage_q <= '0;
                else if (ce_i && (do_sync || do_async))
                    stage_q <= result;
            end

            // Active width register
            always_ff @(posedge mclk_i)
            begin
                if (srst)
                    active_q <= '0;
                else if (ce_i)
                begin
                    if (do_async)
                        active_q <= result;
                    else if (period_start && pend_q)
                        active_q <= stage_q;
                end
            end

            // Comparison output
            always_ff @(posedge mclk_i)
            begin
                if (srst)
                    pwm_o[g] <= 1'b0;
                else if (ce_i)
                    pwm_o[g] <= oe_q & allow_q & (mcnt_q < active_q);
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic apb_acc, apb_wr;
    assign apb_acc = psel_i & penable_i & ~pready_o;
    assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    assign sync_clr = apb_wr & (paddr_i == REG_STATUS) & pwdata_i[STAT_SYNC];

    // One wait state, then answer with registered data
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end
        else if (ce_i)
        begin
            pready_o <= apb_acc;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
            if (apb_acc)
            begin
                case (paddr_i)
                    REG_CTRL: prdata_o <= {31'h0, allow_q};
                    REG_STATUS:
                    begin
                        if (!pwrite_i)
                        begin
                            prdata_o[STAT_SYNC] <= sync_err_q;
                            prdata_o[STAT_CRD] <= crd_q;
                            prdata_o[STAT_OE] <= oe_q;
                            prdata_o[STAT_PEND] <= pend_q;
                            prdata_o[STAT_CMD_LSB +: CMD_W] <= last_cmd_q;
                        end
                    end
                    REG_COUNT: prdata_o <= {20'h0, mcnt_q};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    // Software output gate
    always_ff @(posedge mclk_i)
    begin
        if (srst)
            allow_q <= CTRL_ALLOW_RST;
        else if (ce_i && apb_wr && paddr_i == REG_CTRL)
            allow_q <= pwdata_i[0];
    end

endmodule
`default_nettype wire

// ### dv/mpwm_host_model.sv
/*
 * Host model: shifts frames into the generator and pulses the latch pin.
 * Assumes the bench clock; one frame bit takes 8 mclk (320 ns).
 */
`timescale 1ns/1ps
`default_nettype none
module mpwm_host_model
(
    input wire logic mclk_i,
    input wire logic serial_out_i,
    output logic shift_clock_o,
    output logic serial_o,
    output logic latch_o,
    output logic [583:0] status_o
);
    // Pins start low, shift clock stands still outside frames
    initial
    begin
        shift_clock_o = 1'b0;
        serial_o = 1'b0;
        latch_o = 1'b0;
        status_o = '0;
    end

    // Send nbits bits top first, collect status, then latch for lat cycles
    task automatic send(input logic [583:0] f, input int nbits, input int lat);
        for (int i = 583; i > 583 - nbits; i--)
        begin
            @(posedge mclk_i);
            shift_clock_o <= 1'b0;
            serial_o <= f[i];
            repeat (4) @(posedge mclk_i);
            status_o[i] <= serial_out_i;
            shift_clock_o <= 1'b1;
            repeat (3) @(posedge mclk_i);
        end
        @(posedge mclk_i);
        shift_clock_o <= 1'b0;
        serial_o <= ~serial_o;
        repeat (4) @(posedge mclk_i);
        latch_o <= 1'b1;
        repeat (lat) @(posedge mclk_i);
        latch_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// ### dv/mpwm_top_asserts.sv
/*
 * Port checker for the pulse-width generator.
 * Assumes binding to the top module; ce_i is held high.
 */
`timescale 1ns/1ps
`default_nettype none
module mpwm_top_asserts
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic shift_clock_in_i,
    input wire logic latch_blank_pin_i,
    input wire logic modulation_clock_i,
    input wire logic shift_clock_out_o,
    input wire logic serial_out_o,
    input wire logic [mpwm_pkg::NUM_CH-1:0] pwm_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o
);
    import mpwm_pkg::*;
    logic [10:0] high_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Cycles the latch pin has stood high
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || !latch_blank_pin_i)
            high_q <= 11'h000;
        else if (high_q != 11'h7FF)
            high_q <= high_q + 11'h001;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_rst_out; disable iff (1'b0) rst_i |=> pwm_o == '0 && !serial_out_o; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs live in reset");
    property p_sck_copy; $changed(shift_clock_in_i) |-> ##3 shift_clock_out_o == $past(shift_clock_in_i, 3); endproperty
    a_sck_copy: assert property (p_sck_copy) else $error("shift clock copy wrong");
    property p_blank; high_q > BLANK_CYC + 10 |-> pwm_o == '0; endproperty
    a_blank: assert property (p_blank) else $error("pwm live in blank");
    property p_sdo_hold; (!shift_clock_in_i && !latch_blank_pin_i)[*6] |=> $stable(serial_out_o); endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("serial out moved");
    property p_pwm_hold; (!latch_blank_pin_i && !psel_i && $stable(modulation_clock_i))[*6] |=> $stable(pwm_o); endproperty
    a_pwm_hold: assert property (p_pwm_hold) else $error("pwm moved idle");
    property p_apb_pulse; pready_o |=> !pready_o; endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("pready too long");
    property p_apb_answer; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("pready missing");
    property p_apb_err; pslverr_o |-> pready_o && psel_i && penable_i; endproperty
    a_apb_err: assert property (p_apb_err) else $error("stray pslverr");

    c_err: cover property (pready_o && pslverr_o);
    c_blank: cover property (high_q == 11'h514);
    c_pwm: cover property (pwm_o != '0 && pwm_o != '1);
endmodule
`default_nettype wire

// ### dv/mpwm_top_tb.sv
/*
 * Self-checking bench: frames from the host model, state read over APB.
 * Assumes the host model and checker are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
module mpwm_top_tb;
    import mpwm_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mck = 1'b0;
    logic run = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [1:0] div_q = 2'h0;
    logic [11:0] pad = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic sck, serial_in, ldb, serial_out, prdy, perr, er;
    logic [31:0] prd, rd;
    logic [NUM_CH-1:0] pwm;
    logic [583:0] st, e;
    int err_count = 0;
    int n_compared = 0;
    int j;

    // ----------------------------------------------------------------
    // Clocks, design and host
    // ----------------------------------------------------------------
    // System clock 25 MHz
    initial
    begin
        forever #20 mclk_i = ~mclk_i;
    end

    // Modulation clock, 4 mclk period while run is high
    always @(posedge mclk_i)
    begin
        div_q <= div_q + 2'h1;
        if (run)
            mck <= div_q[1];
    end

    mpwm_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .shift_clock_in_i(sck),
        .serial_in_i(serial_in), .latch_blank_pin_i(ldb), .modulation_clock_i(mck),
        .shift_clock_out_o(), .serial_out_o(serial_out), .pwm_o(pwm), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr));
    mpwm_host_model host (.mclk_i(mclk_i), .serial_out_i(serial_out), .shift_clock_o(sck),
        .serial_o(serial_in), .latch_o(ldb), .status_o(st));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic int val(input int k);
        return k * 85;
    endfunction

    function automatic int correction_setting(input int k);
        return (k == 47) ? 63 : (k * 4) % 64;
    endfunction

    // Frame: channel fields above an 8-bit command
    function automatic logic [583:0] mk(input logic [7:0] cmd, input int mode);
        logic [583:0] f;
        f = '0;
        f[7:0] = cmd;
        for (int k = 0; k < NUM_CH; k++)
            f[8 + 12 * k +: 12] = (mode == 2) ? 12'(correction_setting(k)) : 12'(val(k) >> mode);
        return f;
    endfunction

    task automatic chk(input logic [583:0] got, input logic [583:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwr <= wr;
        pad <= a;
        pwd <= d;
        @(posedge mclk_i);
        pen <= 1'b1;
        for (n = 0; n < 20 && prdy !== 1'b1; n++)
            @(posedge mclk_i);
        if (n == 20)
        begin
            err_count++;
            close_out();
        end
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd & m, x);
    endtask

    // Freeze the counter, read it, compare every output
    task automatic chk_pwm(input int mode, input logic correction_disable_flag, input logic on);
        logic [583:0] x;
        int w;
        run <= 1'b0;
        repeat (8) @(posedge mclk_i);
        apb(1'b0, REG_COUNT, 32'h0);
        x = '0;
        for (int k = 0; k < NUM_CH; k++)
        begin
            w = val(k) >> mode;
            if (!correction_disable_flag)
                w = w * (correction_setting(k) + 32) / 96;
            x[k] = on && (rd < w);
        end
        chk(pwm, x);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        rdc(REG_CTRL, 32'hFFFFFFFF, 32'h1);
        rdc(REG_STATUS, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk({er, rd}, 33'h100000000);
        host.send(mk(8'h20, 2), 584, 20);
        host.send(mk(8'h10, 0), 584, 20);
        e = '0;
        e[583:580] = 4'h2;
        for (j = 0; j < NUM_CH; j++)
            e[288 + 6 * j +: 6] = 6'(correction_setting(j));
        chk(st, e);
        rdc(REG_STATUS, 32'hFFFFFFFF, 32'h100);
        chk_pwm(0, 1'b0, 1'b0);
        host.send(mk(8'h30, 0), 584, 20);
        for (j = 0; j < 3; j++)
        begin
            run <= 1'b1;
            repeat (3000 * j + 400) @(posedge mclk_i);
            chk_pwm(0, 1'b0, 1'b1);
        end
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (3) @(posedge mclk_i);
        chk(pwm, 48'h0);
        apb(1'b1, REG_CTRL, 32'h1);
        host.send(mk(8'h70, 0), 584, 20);
        host.send(mk(8'h10, 0), 584, 20);
        chk(st[583:576], 8'h71);
        chk_pwm(0, 1'b1, 1'b1);
        host.send(mk(8'h00, 1), 584, 20);
        rdc(REG_STATUS, 32'hFFFFFFFF, 32'hE);
        chk_pwm(0, 1'b1, 1'b1);
        run <= 1'b1;
        apb(1'b0, REG_STATUS, 32'h0);
        for (j = 0; j < 6000 && rd[3] !== 1'b0; j++)
            apb(1'b0, REG_STATUS, 32'h0);
        if (j == 6000)
        begin
            err_count++;
            close_out();
        end
        chk_pwm(1, 1'b1, 1'b1);
        host.send(mk(8'h40, 0), 584, 20);
        rdc(REG_STATUS, 32'h4, 32'h0);
        chk(pwm, 48'h0);
        host.send(mk(8'h50, 0), 100, 20);
        rdc(REG_STATUS, 32'h1, 32'h1);
        apb(1'b1, REG_STATUS, 32'h1);
        rdc(REG_STATUS, 32'h1, 32'h0);
        host.send(mk(8'h30, 0), 584, 1400);
        rdc(REG_STATUS, 32'hFFFFFFFF, 32'h0);
        chk(pwm, 48'h0);
        close_out();
    end
endmodule

bind mpwm_top mpwm_top_asserts chk_i (.mclk_i, .rst_i, .shift_clock_in_i, .latch_blank_pin_i,
    .modulation_clock_i, .shift_clock_out_o, .serial_out_o, .pwm_o, .psel_i, .penable_i,
    .pready_o, .pslverr_o);
`default_nettype wire
